// [hdl/hfp_fifo.sv]
// Synchronous FIFO with a run-time capacity limit and registered outputs.
// Assumes a power-of-two depth; rst clears contents synchronously.
`timescale 1ns/1ps
module hfp_fifo #(
    parameter int unsigned W = 32,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned CW = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Capacity limit
    input wire logic [CW-1:0] lim,
    // Filling side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready,
    // Fill level
    output logic [CW-1:0] level
);
    localparam int unsigned PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] cnt;
        logic in_ready;
        logic out_valid;
        logic [W-1:0] dout;
    } hfp_fifo_s;

    hfp_fifo_s q;
    hfp_fifo_s d;
    logic push;
    logic pop;

    // Next state: push, pop, then recompute flags and head word
    always_comb begin
        d = q;
        push = in_valid & q.in_ready;
        pop = out_ready & q.out_valid;
        if (push) begin
            d.mem[q.wr_ptr] = in_data;
            d.wr_ptr = PW'(q.wr_ptr + 1'b1);
        end
        if (pop) begin
            d.rd_ptr = PW'(q.rd_ptr + 1'b1);
        end
        d.cnt = CW'(q.cnt + CW'(push) - CW'(pop));
        d.in_ready = (d.cnt < lim) && (d.cnt < CW'(DEPTH));
        d.out_valid = (d.cnt != '0);
        d.dout = d.mem[d.rd_ptr];
        if (rst) begin
            d = '0;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign in_ready = q.in_ready;
    assign out_valid = q.out_valid;
    assign out_data = q.dout;
    assign level = q.cnt;
endmodule

// [hdl/hfp_host_ports.sv]
// Host-facing queue ports and register access classes.
// Assumes host inputs synchronous to core_clk; one access per cycle.
`timescale 1ns/1ps
module hfp_host_ports #(
    parameter int unsigned DATA_W = hfp_pkg::DATA_W,
    parameter int unsigned DEPTH = hfp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Host bus
    input wire logic host_cs,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [hfp_pkg::ADDR_W-1:0] host_addr,
    input wire logic [DATA_W-1:0] host_wdata,
    output logic [DATA_W-1:0] host_rdata_q,
    output logic host_rvalid_q,
    // Receive data from the link side
    input wire logic rxd_valid,
    input wire logic [DATA_W-1:0] rxd_data,
    output logic rxd_ready,
    // Receive status from the link side
    input wire logic rxs_valid,
    input wire logic [DATA_W-1:0] rxs_data,
    output logic rxs_ready,
    // Transmit status from the link side
    input wire logic txs_valid,
    input wire logic [DATA_W-1:0] txs_data,
    output logic txs_ready,
    // Transmit data to the link side
    output logic txd_valid,
    output logic [DATA_W-1:0] txd_data,
    input wire logic txd_ready,
    // Condition levels to latch
    input wire logic err_level,
    input wire logic link_level
);
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam int unsigned NF = hfp_pkg::NUM_FIFO;

    // Alias hit: compare only the bits above the alias window
    function automatic logic is_alias(input logic [hfp_pkg::IDX_W-1:0] idx,
                                      input logic [hfp_pkg::IDX_W-1:0] base);
        is_alias = idx[hfp_pkg::IDX_W-1:hfp_pkg::ALIAS_BITS] ==
                   base[hfp_pkg::IDX_W-1:hfp_pkg::ALIAS_BITS];
    endfunction

    // Status queue hit: its pop or its peek address
    function automatic logic is_pair(input logic [hfp_pkg::IDX_W-1:0] idx,
                                     input logic [hfp_pkg::IDX_W-1:0] pop_idx,
                                     input logic [hfp_pkg::IDX_W-1:0] peek_idx);
        is_pair = (idx == pop_idx) || (idx == peek_idx);
    endfunction

    hfp_pkg::hfp_top_s q;
    hfp_pkg::hfp_top_s d;

    logic [hfp_pkg::IDX_W-1:0] idx;
    logic rd_acc;
    logic wr_acc;
    logic any_rst;
    logic rxd_hit;
    logic txd_hit;
    logic rxs_hit;
    logic txs_hit;
    logic [NF-1:0] f_in_v;
    logic [NF-1:0][DATA_W-1:0] f_in_d;
    logic [NF-1:0] f_in_r;
    logic [NF-1:0] f_out_v;
    logic [NF-1:0][DATA_W-1:0] f_out_d;
    logic [NF-1:0] f_out_r;
    logic [NF-1:0][CW-1:0] f_cnt;
    logic [31:0] lvl_word;
    logic [hfp_pkg::FLG_W-1:0] flg_set;
    logic [hfp_pkg::FLG_W-1:0] flg_clr;
    logic [hfp_pkg::FLG_W-1:0] flg;
    logic [hfp_pkg::EVT_W-1:0] evt_set;
    logic [hfp_pkg::EVT_W-1:0] evt_clr;
    logic [hfp_pkg::EVT_W-1:0] evt;
    logic [hfp_pkg::LAT_W-1:0] lat_set;
    logic [hfp_pkg::LAT_W-1:0] lat_clr;
    logic [hfp_pkg::LAT_W-1:0] lat;
    logic [DATA_W-1:0] rd_val;

    // Access decode; a read wins when both strobes are high
    assign idx = host_addr[hfp_pkg::ADDR_W-1:2];
    assign rd_acc = host_cs & host_rd;
    assign wr_acc = host_cs & host_wr & ~host_rd;
    // Soft reset acts one cycle after its write; an access then is lost
    assign any_rst = rst | q.srst;

    // Port hits, decoded once; status pop strobes and the read case decode idx themselves
    assign rxd_hit = is_alias(idx, hfp_pkg::IDX_RXD_BASE);
    assign txd_hit = is_alias(idx, hfp_pkg::IDX_TXD_BASE);
    assign rxs_hit = is_pair(idx, hfp_pkg::IDX_RXS_POP, hfp_pkg::IDX_RXS_PEEK);
    assign txs_hit = is_pair(idx, hfp_pkg::IDX_TXS_POP, hfp_pkg::IDX_TXS_PEEK);

    // Queue filling sides
    always_comb begin
        f_in_v = '0;
        f_in_d = '0;
        f_in_v[hfp_pkg::F_RXD] = rxd_valid;
        f_in_d[hfp_pkg::F_RXD] = rxd_data;
        f_in_v[hfp_pkg::F_RXS] = rxs_valid;
        f_in_d[hfp_pkg::F_RXS] = rxs_data;
        f_in_v[hfp_pkg::F_TXS] = txs_valid;
        f_in_d[hfp_pkg::F_TXS] = txs_data;
        f_in_v[hfp_pkg::F_TXD] = wr_acc & txd_hit;
        f_in_d[hfp_pkg::F_TXD] = host_wdata;
    end

    // Queue draining sides; peek addresses never pop
    always_comb begin
        f_out_r = '0;
        f_out_r[hfp_pkg::F_RXD] = rd_acc & rxd_hit;
        f_out_r[hfp_pkg::F_RXS] = rd_acc & (idx == hfp_pkg::IDX_RXS_POP);
        f_out_r[hfp_pkg::F_TXS] = rd_acc & (idx == hfp_pkg::IDX_TXS_POP);
        f_out_r[hfp_pkg::F_TXD] = txd_ready;
    end

    // Four queues, each capped by its own config field
    // A limit above the depth is clamped inside each queue
    for (genvar i = 0; i < NF; i++) begin : g_fifo
        hfp_fifo #(
            .W(DATA_W),
            .DEPTH(DEPTH),
            .CW(CW)
        ) u_fifo (
            .clk(core_clk),
            .rst(any_rst),
            .lim(q.cfg[i*hfp_pkg::CFG_STRIDE +: CW]),
            .in_valid(f_in_v[i]),
            .in_data(f_in_d[i]),
            .in_ready(f_in_r[i]),
            .out_valid(f_out_v[i]),
            .out_data(f_out_d[i]),
            .out_ready(f_out_r[i]),
            .level(f_cnt[i])
        );
        assign lvl_word[i*hfp_pkg::CFG_STRIDE +: hfp_pkg::CFG_STRIDE] =
            hfp_pkg::CFG_STRIDE'(f_cnt[i]);
    end

    // Link-side handshake outputs come from queue flops
    assign rxd_ready = f_in_r[hfp_pkg::F_RXD];
    assign rxs_ready = f_in_r[hfp_pkg::F_RXS];
    assign txs_ready = f_in_r[hfp_pkg::F_TXS];
    assign txd_valid = f_out_v[hfp_pkg::F_TXD];
    assign txd_data = f_out_d[hfp_pkg::F_TXD];

    // Error flags: overflow on full write, underrun on empty read
    always_comb begin
        flg_set = '0;
        flg_set[hfp_pkg::FLG_TXD_OVF] = f_in_v[hfp_pkg::F_TXD] & ~f_in_r[hfp_pkg::F_TXD];
        flg_set[hfp_pkg::FLG_RXD_UND] = f_out_r[hfp_pkg::F_RXD] & ~f_out_v[hfp_pkg::F_RXD];
        flg_set[hfp_pkg::FLG_RXS_UND] = rd_acc & ~f_out_v[hfp_pkg::F_RXS] & rxs_hit;
        flg_set[hfp_pkg::FLG_TXS_UND] = rd_acc & ~f_out_v[hfp_pkg::F_TXS] & txs_hit;
        // An event in the clearing cycle wins; the bank sets last
        flg_clr = '0;
        if (wr_acc && idx == hfp_pkg::IDX_FLAGS) begin
            flg_clr = host_wdata[hfp_pkg::FLG_W-1:0];
        end
    end

    hfp_sticky #(
        .W(hfp_pkg::FLG_W)
    ) u_flags (
        .clk(core_clk),
        .rst(any_rst),
        .set(flg_set),
        .clr(flg_clr),
        .flags(flg)
    );

    // Arrival events, cleared by reading them
    always_comb begin
        evt_set = '0;
        evt_set[hfp_pkg::EVT_RXS] = rxs_valid & f_in_r[hfp_pkg::F_RXS];
        evt_set[hfp_pkg::EVT_TXS] = txs_valid & f_in_r[hfp_pkg::F_TXS];
        evt_clr = {hfp_pkg::EVT_W{rd_acc && idx == hfp_pkg::IDX_EVENTS}};
    end

    hfp_sticky #(
        .W(hfp_pkg::EVT_W)
    ) u_events (
        .clk(core_clk),
        .rst(any_rst),
        .set(evt_set),
        .clr(evt_clr),
        .flags(evt)
    );

    // Latch-high on error, latch-low on link; read releases
    always_comb begin
        lat_set = '0;
        lat_set[hfp_pkg::LAT_ERR] = err_level;
        lat_set[hfp_pkg::LAT_LINK] = ~link_level;
        // A condition still present at the read sets the bit again
        lat_clr = {hfp_pkg::LAT_W{rd_acc && idx == hfp_pkg::IDX_LATCH}};
    end

    hfp_sticky #(
        .W(hfp_pkg::LAT_W)
    ) u_latch (
        .clk(core_clk),
        .rst(any_rst),
        .set(lat_set),
        .clr(lat_clr),
        .flags(lat)
    );

    // Read data select
    // Data ports decode on the upper index bits only
    always_comb begin
        rd_val = '0;
        if (rxd_hit) begin
            rd_val = f_out_d[hfp_pkg::F_RXD];
        end else if (txd_hit) begin
            rd_val = '0;
        end else begin
            case (idx)
                hfp_pkg::IDX_RXS_POP,
                hfp_pkg::IDX_RXS_PEEK: begin
                    rd_val = f_out_d[hfp_pkg::F_RXS];
                end
                hfp_pkg::IDX_TXS_POP,
                hfp_pkg::IDX_TXS_PEEK: begin
                    rd_val = f_out_d[hfp_pkg::F_TXS];
                end
                hfp_pkg::IDX_CFG: begin
                    rd_val = DATA_W'(q.cfg);
                end
                hfp_pkg::IDX_LEVEL: begin
                    rd_val = DATA_W'(lvl_word);
                end
                hfp_pkg::IDX_FLAGS: begin
                    rd_val = DATA_W'(flg);
                end
                hfp_pkg::IDX_EVENTS: begin
                    rd_val = DATA_W'(evt);
                end
                hfp_pkg::IDX_LATCH: begin
                    rd_val = DATA_W'({~lat[hfp_pkg::LAT_LINK], lat[hfp_pkg::LAT_ERR]});
                end
                hfp_pkg::IDX_SRST: begin
                    rd_val = '0;
                end
                hfp_pkg::IDX_KEEP: begin
                    rd_val = DATA_W'(q.keep);
                end
                default: begin
                    rd_val = '0;
                end
            endcase
        end
        // Empty queues answer zero rather than a stale head
        if (!f_out_v[hfp_pkg::F_RXD] && rxd_hit) begin
            rd_val = '0;
        end
        if (!f_out_v[hfp_pkg::F_RXS] && rxs_hit) begin
            rd_val = '0;
        end
        if (!f_out_v[hfp_pkg::F_TXS] && txs_hit) begin
            rd_val = '0;
        end
    end

    // Register next state; only cfg, keep and soft reset are writable
    always_comb begin
        d = q;
        d.rvalid = rd_acc;
        d.rdata = rd_acc ? rd_val : '0;
        d.srst = wr_acc && (idx == hfp_pkg::IDX_SRST) && host_wdata[hfp_pkg::SRST_BIT];
        // Reserved config bits are masked so they read back zero
        if (wr_acc && idx == hfp_pkg::IDX_CFG) begin
            d.cfg = host_wdata[31:0] & hfp_pkg::CFG_MASK;
        end
        if (wr_acc && idx == hfp_pkg::IDX_KEEP) begin
            d.keep = host_wdata[31:0];
        end
        // Soft reset restores all but the keep register
        if (q.srst) begin
            d.cfg = hfp_pkg::CFG_RST;
            d.srst = 1'b0;
            d.rvalid = 1'b0;
            d.rdata = '0;
            d.keep = q.keep;
        end
        if (rst) begin
            d = '0;
            d.cfg = hfp_pkg::CFG_RST;
            d.keep = hfp_pkg::KEEP_RST;
        end
    end

    always_ff @(posedge core_clk) begin
        q <= d;
    end

    // Host answer outputs
    assign host_rdata_q = q.rdata;
    assign host_rvalid_q = q.rvalid;
endmodule

// [hdl/hfp_pkg.sv]
// Constants, word map and state type for the host FIFO port block.
// Assumes a host on a simple one-cycle memory-like bus, 32-bit words.
package hfp_pkg;

    // Widths and depth
    localparam int unsigned DATA_W = 32;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned IDX_W = 6;
    localparam int unsigned ALIAS_BITS = 4;
    localparam int unsigned NUM_FIFO = 4;

    // Word indices, byte address is four times the index
    localparam logic [5:0] IDX_RXD_BASE = 6'h00;
    localparam logic [5:0] IDX_TXD_BASE = 6'h10;
    localparam logic [5:0] IDX_RXS_POP = 6'h20;
    localparam logic [5:0] IDX_RXS_PEEK = 6'h21;
    localparam logic [5:0] IDX_TXS_POP = 6'h22;
    localparam logic [5:0] IDX_TXS_PEEK = 6'h23;
    localparam logic [5:0] IDX_CFG = 6'h24;
    localparam logic [5:0] IDX_LEVEL = 6'h25;
    localparam logic [5:0] IDX_FLAGS = 6'h26;
    localparam logic [5:0] IDX_EVENTS = 6'h27;
    localparam logic [5:0] IDX_LATCH = 6'h28;
    localparam logic [5:0] IDX_SRST = 6'h29;
    localparam logic [5:0] IDX_KEEP = 6'h2A;

    // Queue numbering
    localparam int unsigned F_RXD = 0;
    localparam int unsigned F_RXS = 1;
    localparam int unsigned F_TXS = 2;
    localparam int unsigned F_TXD = 3;

    // Config limit fields, one byte per queue
    localparam int unsigned CFG_STRIDE = 8;
    localparam logic [31:0] CFG_MASK = 32'h0F0F0F0F;
    localparam logic [31:0] CFG_RST = 32'h08080808;
    localparam logic [31:0] KEEP_RST = 32'h00000000;
    localparam int unsigned SRST_BIT = 0;

    // Flag bit positions
    localparam int unsigned FLG_TXD_OVF = 0;
    localparam int unsigned FLG_RXD_UND = 1;
    localparam int unsigned FLG_RXS_UND = 2;
    localparam int unsigned FLG_TXS_UND = 3;
    localparam int unsigned FLG_W = 4;
    localparam int unsigned EVT_RXS = 0;
    localparam int unsigned EVT_TXS = 1;
    localparam int unsigned EVT_W = 2;
    localparam int unsigned LAT_ERR = 0;
    localparam int unsigned LAT_LINK = 1;
    localparam int unsigned LAT_W = 2;

    // Top-level register state
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] keep;
        logic srst;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
    } hfp_top_s;

endpackage

// [hdl/hfp_sticky.sv]
// Sticky flag bank: a set holds the bit, a clear drops it, set wins.
// Serves write-one-to-clear, read-to-clear and latching bits alike.
`timescale 1ns/1ps
module hfp_sticky #(
    parameter int unsigned W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Events and clears
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    // Held flags
    output logic [W-1:0] flags
);
    typedef struct packed {
        logic [W-1:0] bits;
    } hfp_sticky_s;

    hfp_sticky_s q;
    hfp_sticky_s d;

    // Clear first, then the event sets again
    always_comb begin
        d = q;
        d.bits = (q.bits & ~clr) | set;
        if (rst) begin
            d = '0;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign flags = q.bits;
endmodule

// [test/hfp_link_model.sv]
// Link-side partner: fills receive and status queues, drains transmit data.
// Driven by task calls from the testbench; stall holds transmit data back.
`timescale 1ns/1ps
module hfp_link_model (
    // Clock and control
    input wire logic core_clk,
    input wire logic stall,
    // Fill sides
    output logic rxd_valid,
    output logic [31:0] rxd_data,
    input wire logic rxd_ready,
    output logic rxs_valid,
    output logic [31:0] rxs_data,
    input wire logic rxs_ready,
    output logic txs_valid,
    output logic [31:0] txs_data,
    input wire logic txs_ready,
    // Drain side
    input wire logic txd_valid,
    input wire logic [31:0] txd_data,
    output logic txd_ready = 1'b0
);
    logic [2:0] v = 3'h0;
    logic [31:0] d [3] = '{default: 32'h0};
    logic [2:0] rdy_n = 3'h0;
    logic tv_n = 1'b0;
    logic [31:0] td_n = 32'h0;
    logic [31:0] got [$];

    // Per-queue source signals
    assign {txs_valid, rxs_valid, rxd_valid} = v;
    assign rxd_data = d[0];
    assign rxs_data = d[1];
    assign txs_data = d[2];

    // Values as they stood before the next rising edge
    always @(negedge core_clk) begin
        rdy_n <= {txs_ready, rxs_ready, rxd_ready};
        tv_n <= txd_valid;
        td_n <= txd_data;
    end

    // One word per handshake, held until taken
    task automatic send(input int k, input logic [31:0] w);
        @(posedge core_clk);
        v[k] <= 1'b1;
        d[k] <= w;
        do @(posedge core_clk); while (!rdy_n[k]);
        v[k] <= 1'b0;
        d[k] <= ~w; // Stale data never repeats
    endtask

    // Drain with optional stall
    always @(posedge core_clk) begin
        if (tv_n && txd_ready) begin
            got.push_back(td_n);
        end
        txd_ready <= !stall;
    end
endmodule

// [test/hfp_props.sv]
// Concurrent checks on the host queue port block's top-level pins.
// Bound to hfp_host_ports from the testbench; a single clock domain.
`timescale 1ns/1ps
module hfp_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Host bus
    input wire logic host_cs,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [hfp_pkg::ADDR_W-1:0] host_addr,
    input wire logic [hfp_pkg::DATA_W-1:0] host_wdata,
    input wire logic [hfp_pkg::DATA_W-1:0] host_rdata_q,
    input wire logic host_rvalid_q,
    // Link sides
    input wire logic rxs_valid,
    input wire logic txs_valid,
    input wire logic rxd_ready,
    input wire logic rxs_ready,
    input wire logic txs_ready,
    input wire logic txd_valid,
    input wire logic [hfp_pkg::DATA_W-1:0] txd_data,
    input wire logic txd_ready
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // Transmit data write while the drain side is empty
    sequence txd_wr;
        host_cs && host_wr && !host_rd && host_addr[7:6] == 2'b01 && !txd_valid;
    endsequence
    // Two back-to-back peeks with no new entry arriving
    sequence peek_twice(a, v);
        (host_cs && host_rd && host_addr == a && !v)[*2];
    endsequence

    a_read_answered: assert property (host_cs && host_rd |=> host_rvalid_q)
        else $error("read got no answer");
    a_no_stray_answer: assert property (!(host_cs && host_rd) |=> !host_rvalid_q)
        else $error("answer without a read");
    a_idle_data_zero: assert property (!host_rvalid_q |-> host_rdata_q == '0)
        else $error("read data not zero while idle");
    a_wo_reads_zero: assert property (host_cs && host_rd && host_addr[7:6] == 2'b01
        |=> host_rdata_q == '0)
        else $error("transmit data port read not zero");
    a_txd_write_enters: assert property (txd_wr |=> txd_valid
        && txd_data == $past(host_wdata))
        else $error("transmit word did not reach drain side");
    a_txd_holds: assert property (txd_valid && !txd_ready |=> txd_valid
        && $stable(txd_data))
        else $error("transmit word changed while stalled");
    a_rxs_peek_keeps: assert property (peek_twice(8'h84, rxs_valid)
        |=> host_rdata_q == $past(host_rdata_q))
        else $error("receive status peek moved the head");
    a_txs_peek_keeps: assert property (peek_twice(8'h8C, txs_valid)
        |=> host_rdata_q == $past(host_rdata_q))
        else $error("transmit status peek moved the head");
    a_ready_after_rst: assert property ($fell(rst)
        |-> ##[0:2] (rxd_ready && rxs_ready && txs_ready))
        else $error("queues not ready after reset");
endmodule

// [test/testbench.sv]
// Self-checking bench for the host queue ports with the link model beside it.
// Assumes the package, design, checker and link model are compiled first.
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic host_cs = 1'b0;
    logic host_rd = 1'b0;
    logic host_wr = 1'b0;
    logic [7:0] host_addr = 8'h00;
    logic [31:0] host_wdata = 32'h0;
    logic [31:0] host_rdata_q, rxd_data, rxs_data, txs_data, txd_data, rd_v, seed, w [4];
    logic host_rvalid_q, rxd_valid, rxd_ready, rxs_valid, rxs_ready;
    logic txs_valid, txs_ready, txd_valid, txd_ready;
    logic err_level = 1'b0;
    logic link_level = 1'b1;
    logic stall = 1'b0;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;

    // Clock
    always #5 core_clk = ~core_clk;

    hfp_host_ports i_dut (.core_clk(core_clk), .rst(rst), .host_cs(host_cs),
        .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata_q(host_rdata_q), .host_rvalid_q(host_rvalid_q),
        .rxd_valid(rxd_valid), .rxd_data(rxd_data), .rxd_ready(rxd_ready),
        .rxs_valid(rxs_valid), .rxs_data(rxs_data), .rxs_ready(rxs_ready),
        .txs_valid(txs_valid), .txs_data(txs_data), .txs_ready(txs_ready),
        .txd_valid(txd_valid), .txd_data(txd_data), .txd_ready(txd_ready),
        .err_level(err_level), .link_level(link_level));

    hfp_link_model i_link (.core_clk(core_clk), .stall(stall),
        .rxd_valid(rxd_valid), .rxd_data(rxd_data), .rxd_ready(rxd_ready),
        .rxs_valid(rxs_valid), .rxs_data(rxs_data), .rxs_ready(rxs_ready),
        .txs_valid(txs_valid), .txs_data(txs_data), .txs_ready(txs_ready),
        .txd_valid(txd_valid), .txd_data(txd_data), .txd_ready(txd_ready));

    // Pseudo-random words
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected fill-level word, one byte per queue
    function automatic logic [31:0] lvl(input int a, input int b, input int c, input int e);
        return {e[7:0], c[7:0], b[7:0], a[7:0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("mismatches %0d of %0d checks", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One host access; released lines never show the last value
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        host_cs <= 1'b1;
        host_rd <= !wr;
        host_wr <= wr;
        host_addr <= a;
        host_wdata <= d;
        @(posedge core_clk);
        host_cs <= 1'b0;
        host_rd <= 1'b0;
        host_wr <= 1'b0;
        host_addr <= ~a;
        host_wdata <= ~d;
        @(negedge core_clk);
        rd_v = host_rdata_q;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(rd_v, exp);
    endtask

    // Two back-to-back reads of one peek port
    task automatic peek2(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        host_cs <= 1'b1;
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge core_clk);
        @(negedge core_clk);
        chk(host_rdata_q, exp);
        @(posedge core_clk);
        host_cs <= 1'b0;
        host_rd <= 1'b0;
        @(negedge core_clk);
        chk(host_rdata_q, exp);
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // Main sequence
    initial begin
        seed = 32'h4FFEAA5C;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rdc(8'h90, 32'h08080808);
        rdc(8'hA8, 32'h0);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            w[i] = seed;
            i_link.send(0, seed);
        end
        acc(1'b1, 8'h94, 32'hFFFFFFFF);
        acc(1'b1, 8'h00, 32'h0);
        rdc(8'h94, lvl(4, 0, 0, 0));
        rdc(8'h00, w[0]);
        rdc(8'h3C, w[1]);
        rdc(8'h17, w[2]);
        rdc(8'h28, w[3]);
        rdc(8'h04, 32'h0);
        // Empty-read flag: zero write keeps it, one write clears it
        rdc(8'h98, 32'h2);
        acc(1'b1, 8'h98, 32'h0);
        rdc(8'h98, 32'h2);
        acc(1'b1, 8'h98, 32'h2);
        rdc(8'h98, 32'h0);
        // Status queues: events, peek, pop
        for (int k = 1; k < 3; k++) begin
            seed = lfsr(seed);
            w[0] = seed;
            i_link.send(k, seed);
            seed = lfsr(seed);
            w[1] = seed;
            i_link.send(k, seed);
            rdc(8'h9C, 32'(k));
            rdc(8'h9C, 32'h0);
            peek2(8'h7C + 8'(k * 8), w[0]);
            rdc(8'h78 + 8'(k * 8), w[0]);
            rdc(8'h78 + 8'(k * 8), w[1]);
        end
        // Empty status ports answer zero and raise their underrun flags
        rdc(8'h84, 32'h0);
        rdc(8'h88, 32'h0);
        rdc(8'h98, 32'hC);
        acc(1'b1, 8'h98, 32'hC);
        // Latched conditions
        @(posedge core_clk);
        err_level <= 1'b1;
        link_level <= 1'b0;
        @(posedge core_clk);
        err_level <= 1'b0;
        link_level <= 1'b1;
        rdc(8'hA0, 32'h1);
        rdc(8'hA0, 32'h2);
        // Transmit data fills to its limit while the far side stalls
        stall <= 1'b1;
        acc(1'b1, 8'h90, 32'h03080808);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            w[i] = seed;
            acc(1'b1, 8'h40 + 8'(i * 20), seed);
        end
        rdc(8'h94, lvl(0, 0, 0, 3));
        rdc(8'h98, 32'h1);
        rdc(8'h44, 32'h0);
        stall <= 1'b0;
        for (int i = 0; i < 50 && i_link.got.size() < 3; i++) @(posedge core_clk);
        for (int i = 0; i < 3; i++) chk(i_link.got[i], w[i]);
        chk(32'(i_link.got.size()), 32'h3);
        // Soft reset keeps one register, restores the rest
        seed = lfsr(seed);
        acc(1'b1, 8'hA8, seed);
        acc(1'b1, 8'hA4, 32'h1);
        repeat (3) @(posedge core_clk);
        rdc(8'hA8, seed);
        rdc(8'h90, 32'h08080808);
        rdc(8'h98, 32'h0);
        rdc(8'hA4, 32'h0);
        // System reset in mid-run clears even the kept register
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rdc(8'hA8, 32'h0);
        rdc(8'h90, 32'h08080808);
        tally_and_finish();
    end
endmodule

bind hfp_host_ports hfp_props i_props (.core_clk(core_clk), .rst(rst),
    .host_cs(host_cs), .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata_q(host_rdata_q), .host_rvalid_q(host_rvalid_q),
    .rxs_valid(rxs_valid), .txs_valid(txs_valid), .rxd_ready(rxd_ready),
    .rxs_ready(rxs_ready), .txs_ready(txs_ready), .txd_valid(txd_valid),
    .txd_data(txd_data), .txd_ready(txd_ready));
